// File: src/mpft_pkg.sv
// package for the motor pwm block: register map, field positions, types
// assumes a 32-bit apb master with byte addresses on paddr[7:0]
package mpft_pkg;
  localparam int CNT_W = 16;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MPER = 8'h04;
  localparam logic [7:0] OFF_SEVT = 8'h08;
  localparam logic [7:0] OFF_CHOP = 8'h0c;
  localparam logic [7:0] OFF_GEN0 = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h40;
  localparam logic [7:0] OFF_MASK = 8'h44;
  localparam logic [7:0] OFF_FLTS = 8'h48;
  // word offsets inside a generator's 16-byte group
  localparam logic [1:0] GW_PER = 2'h0;
  localparam logic [1:0] GW_DUTY = 2'h1;
  localparam logic [1:0] GW_TRIG = 2'h2;
  localparam logic [1:0] GW_FCL = 2'h3;
  // control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_CENTER = 1;
  localparam int CTRL_SWAP = 2;
  localparam int CTRL_CHOP = 3;
  localparam int CTRL_PRE_LO = 4;
  localparam int CTRL_SYNC_EN = 7;
  localparam int CTRL_FCLR = 8;
  // fault_limit_control fields
  localparam int FCL_CL_EN = 2;
  localparam int FCL_LOCAL = 3;
  localparam int FCL_SAFE_H = 4;
  localparam int FCL_SAFE_L = 5;
  // fault_mode_select encodings
  localparam logic [1:0] FMODE_LATCH = 2'h0;
  localparam logic [1:0] FMODE_CYCLE = 2'h1;
  localparam logic [1:0] FMODE_OFF = 2'h3;
  // status / mask bits
  localparam int ST_SEVT = 0;
  localparam int ST_SYNC = 1;
  localparam int ST_FLT = 2;
  localparam int ST_TRIG0 = 3;
  localparam int ST_W = 6;
  // reset values
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [15:0] PER_RST = 16'hffff;
  localparam logic [15:0] TRIG_RST = 16'h0000;
  localparam logic [5:0] FCL_RST = 6'h00;
  // timing: one count per prescaled pclk
  localparam int CLK_NS = 40;
  localparam int STEP_CYC = 1;
  typedef struct packed {
    logic hi;
    logic lo;
  } mpft_pair_s;
endpackage

// File: src/mpft_top.sv
// three-generator complementary pwm with faults, sync and adc triggers
// assumes apb master on pclk; fault, limit and sync pins are asynchronous
`timescale 1ns/100ps
// Behaviour
// - three generators each drive a high and a low output, six total
// - every pair has its own period and duty setting
// - timing steps are one prescaled tick, the finest step here
// - edge-aligned mode keeps the same tick-based step
// - master counter gives a shared time base to non-local generators
// - enabled fault or limit input forces outputs to programmed safe
// - local time base: 16-bit compare match raises adc trigger
// - special event trigger to adc from master time base compare
// - external sync input restarts master; sync output at rollover
// - safety fault pin stays owned by this block through reset
// - reset leaves faults latched so outputs start safe
// - fault mode writes act regardless of safety input level
// - high and low outputs can be swapped between pins
// - chop gating mode and input clock prescaler
// - each pair has two fault and two limit inputs, ORed to act on both outputs
module mpft_top #(
  parameter int NGEN = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] fault_in,
  input wire logic [5:0] limit_in,
  input wire logic safety_fault_input,
  input wire logic external_sync_input,
  output logic external_sync_output,
  output logic safety_fault_owned,
  output mpft_pkg::mpft_pair_s [NGEN-1:0] pwm_pair,
  output logic [NGEN-1:0] adc_trig,
  output logic adc_sevt,
  output logic irq
);
  localparam int W = mpft_pkg::CNT_W;

  // generator index of a generator-group address, or 3 if none
  function automatic logic [1:0] gen_of(input logic [7:0] a);
    logic [3:0] grp;
    grp = a[7:4];
    if (grp >= 4'h1 && grp <= 4'(NGEN))
      gen_of = 2'(grp - 4'h1);
    else
      gen_of = 2'h3;
  endfunction

  logic [8:0] ctrl_ff;
  logic [W-1:0] mper_ff;
  logic [W-1:0] sevt_ff;
  logic [W-1:0] chop_ff;
  logic [W-1:0] per_ff [NGEN];
  logic [W-1:0] duty_ff [NGEN];
  logic [W-1:0] trig_ff [NGEN];
  logic [5:0] fcl_ff [NGEN];
  logic [mpft_pkg::ST_W-1:0] stat_ff;
  logic [mpft_pkg::ST_W-1:0] mask_ff;
  logic [NGEN-1:0] flt_lat_ff;
  logic [NGEN-1:0] flt_cyc_ff;
  logic [W-1:0] mcnt_ff;
  logic mdown_ff;
  logic [W-1:0] lcnt_ff [NGEN];
  logic [6:0] pre_ff;
  logic [W-1:0] chcnt_ff;
  logic chop_clk_ff;
  logic [5:0] flt_m_ff, flt_s_ff;
  logic [5:0] lim_m_ff, lim_s_ff;
  logic saf_m_ff, saf_s_ff;
  logic syn_m_ff, syn_s_ff, syn_d_ff;
  logic [31:0] rdata_ff;

  logic setup, acc, wr, rd, mapped;
  logic [1:0] g;
  logic [1:0] gw;
  logic tick;
  logic ext_sync;
  logic mroll;
  logic fclr;
  logic [W-1:0] gcnt [NGEN];
  logic [NGEN-1:0] groll;
  logic [NGEN-1:0] fact;
  logic [NGEN-1:0] lim_act;
  logic [NGEN-1:0] trig_hit;
  logic sevt_hit;
  logic [mpft_pkg::ST_W-1:0] ev;
  logic [NGEN-1:0] hraw, lraw;

  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign g = gen_of(paddr);
  assign gw = paddr[3:2];
  assign mapped = (g != 2'h3) || paddr == mpft_pkg::OFF_CTRL ||
    paddr == mpft_pkg::OFF_MPER || paddr == mpft_pkg::OFF_SEVT ||
    paddr == mpft_pkg::OFF_CHOP || paddr == mpft_pkg::OFF_STAT ||
    paddr == mpft_pkg::OFF_MASK || paddr == mpft_pkg::OFF_FLTS;
  assign wr = acc & pwrite & mapped;
  assign rd = acc & ~pwrite & mapped;
  // zero wait states; unmapped addresses answer with an error
  assign pready = acc;
  assign pslverr = acc & ~mapped;
  assign prdata = rdata_ff;
  assign fclr = wr && paddr == mpft_pkg::OFF_CTRL &&
    pwdata[mpft_pkg::CTRL_FCLR];
  // the safety pin is never handed to another function, even in reset
  assign safety_fault_owned = 1'b1;

  // two-flop synchronisers for every pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_m_ff <= 6'h00;
      flt_s_ff <= 6'h00;
      lim_m_ff <= 6'h00;
      lim_s_ff <= 6'h00;
      // assume the safety pin high until seen low, so faults stay on
      saf_m_ff <= 1'b1;
      saf_s_ff <= 1'b1;
      syn_m_ff <= 1'b0;
      syn_s_ff <= 1'b0;
      syn_d_ff <= 1'b0;
    end else begin
      flt_m_ff <= fault_in;
      flt_s_ff <= flt_m_ff;
      lim_m_ff <= limit_in;
      lim_s_ff <= lim_m_ff;
      saf_m_ff <= safety_fault_input;
      saf_s_ff <= saf_m_ff;
      syn_m_ff <= external_sync_input;
      syn_s_ff <= syn_m_ff;
      syn_d_ff <= syn_s_ff;
    end
  end

  assign ext_sync = ctrl_ff[mpft_pkg::CTRL_SYNC_EN] & syn_s_ff &
    ~syn_d_ff;

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= mpft_pkg::CTRL_RST;
      mper_ff <= mpft_pkg::PER_RST;
      sevt_ff <= mpft_pkg::TRIG_RST;
      chop_ff <= mpft_pkg::PER_RST;
      mask_ff <= '0;
      for (int i = 0; i < NGEN; i++) begin
        per_ff[i] <= mpft_pkg::PER_RST;
        duty_ff[i] <= mpft_pkg::TRIG_RST;
        trig_ff[i] <= mpft_pkg::TRIG_RST;
        fcl_ff[i] <= mpft_pkg::FCL_RST;
      end
    end else if (wr) begin
      case (paddr)
        mpft_pkg::OFF_CTRL: ctrl_ff <= {1'b0, pwdata[7:0]};
        mpft_pkg::OFF_MPER: mper_ff <= pwdata[W-1:0];
        mpft_pkg::OFF_SEVT: sevt_ff <= pwdata[W-1:0];
        mpft_pkg::OFF_CHOP: chop_ff <= pwdata[W-1:0];
        mpft_pkg::OFF_MASK: mask_ff <= pwdata[mpft_pkg::ST_W-1:0];
        default: begin
          if (g != 2'h3) begin
            case (gw)
              mpft_pkg::GW_PER: per_ff[g] <= pwdata[W-1:0];
              mpft_pkg::GW_DUTY: duty_ff[g] <= pwdata[W-1:0];
              mpft_pkg::GW_TRIG: trig_ff[g] <= pwdata[W-1:0];
              // mode bits are taken whatever the safety pin shows
              mpft_pkg::GW_FCL: fcl_ff[g] <= pwdata[5:0];
              default: ;
            endcase
          end
        end
      endcase
    end
  end

  // read data is captured in the setup phase, one cycle before pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
    end else if (setup) begin
      rdata_ff <= '0;
      case (paddr)
        mpft_pkg::OFF_CTRL: rdata_ff[7:0] <= ctrl_ff[7:0];
        mpft_pkg::OFF_MPER: rdata_ff[W-1:0] <= mper_ff;
        mpft_pkg::OFF_SEVT: rdata_ff[W-1:0] <= sevt_ff;
        mpft_pkg::OFF_CHOP: rdata_ff[W-1:0] <= chop_ff;
        mpft_pkg::OFF_STAT: rdata_ff[mpft_pkg::ST_W-1:0] <= stat_ff;
        mpft_pkg::OFF_MASK: rdata_ff[mpft_pkg::ST_W-1:0] <= mask_ff;
        mpft_pkg::OFF_FLTS:
          rdata_ff[7:0] <= {saf_s_ff, 1'b0, flt_cyc_ff, flt_lat_ff};
        default: begin
          if (g != 2'h3) begin
            case (gw)
              mpft_pkg::GW_PER: rdata_ff[W-1:0] <= per_ff[g];
              mpft_pkg::GW_DUTY: rdata_ff[W-1:0] <= duty_ff[g];
              mpft_pkg::GW_TRIG: rdata_ff[W-1:0] <= trig_ff[g];
              mpft_pkg::GW_FCL: rdata_ff[5:0] <= fcl_ff[g];
              default: ;
            endcase
          end
        end
      endcase
    end
  end

  // prescaler: divide pclk by 2**sel; counters advance once per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pre_ff <= '0;
    else if (tick)
      pre_ff <= '0;
    else
      pre_ff <= pre_ff + 7'h01;
  end
  // compare with >= so a smaller divider never waits for a counter wrap
  assign tick = pre_ff >= 7'((8'h01 << ctrl_ff[6:4]) - 8'h01);

  // master time base, up or up/down, restarted by the external sync
  assign mroll = tick && (ctrl_ff[mpft_pkg::CTRL_CENTER] ?
    (mdown_ff && mcnt_ff == '0) : mcnt_ff >= mper_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcnt_ff <= '0;
      mdown_ff <= 1'b0;
    end else if (!ctrl_ff[mpft_pkg::CTRL_EN] || ext_sync) begin
      mcnt_ff <= '0;
      mdown_ff <= 1'b0;
    end else if (tick) begin
      // one count per tick sets the step for duty and period
      if (!ctrl_ff[mpft_pkg::CTRL_CENTER]) begin
        mdown_ff <= 1'b0;
        mcnt_ff <= mroll ? '0 : mcnt_ff + 16'h0001;
      end else if (mdown_ff) begin
        // bottom counted once, so a centre period is twice the period
        mdown_ff <= mcnt_ff != '0 ? 1'b1 : 1'b0;
        mcnt_ff <= mcnt_ff != '0 ? mcnt_ff - 16'h0001 : 16'h0001;
      end else begin
        mdown_ff <= mcnt_ff + 16'h0001 >= mper_ff;
        mcnt_ff <= mcnt_ff + 16'h0001;
      end
    end
  end

  // local time bases, wrapped at their own period and restarted by the external sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NGEN; i++)
        lcnt_ff[i] <= '0;
    end else begin
      for (int i = 0; i < NGEN; i++) begin
        if (!ctrl_ff[mpft_pkg::CTRL_EN] || ext_sync)
          lcnt_ff[i] <= '0;
        else if (tick)
          lcnt_ff[i] <= groll[i] ? '0 : lcnt_ff[i] + 16'h0001;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NGEN; i++) begin
      // non-local generators share the master count
      gcnt[i] = fcl_ff[i][mpft_pkg::FCL_LOCAL] ? lcnt_ff[i] :
        mcnt_ff;
      groll[i] = fcl_ff[i][mpft_pkg::FCL_LOCAL] ?
        (tick && lcnt_ff[i] >= per_ff[i]) : mroll;
      trig_hit[i] = tick && fcl_ff[i][mpft_pkg::FCL_LOCAL] &&
        lcnt_ff[i] == trig_ff[i];
      // any fault of either output of the pair, plus the safety pin
      fact[i] = (|flt_s_ff[2*i +: 2]) | saf_s_ff;
      lim_act[i] = fcl_ff[i][mpft_pkg::FCL_CL_EN] &
        (|lim_s_ff[2*i +: 2]);
      // duty compare; chop gates the high side only
      lraw[i] = ctrl_ff[mpft_pkg::CTRL_EN] && !(gcnt[i] < duty_ff[i]);
      hraw[i] = ctrl_ff[mpft_pkg::CTRL_EN] && gcnt[i] < duty_ff[i] &&
        (!ctrl_ff[mpft_pkg::CTRL_CHOP] || chop_clk_ff);
    end
  end
  assign sevt_hit = tick && ctrl_ff[mpft_pkg::CTRL_EN] &&
    mcnt_ff == sevt_ff;

  // fault latches; the latch starts set so power-up is fail-safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_lat_ff <= '1;
      flt_cyc_ff <= '0;
    end else begin
      for (int i = 0; i < NGEN; i++) begin
        case (fcl_ff[i][1:0])
          mpft_pkg::FMODE_LATCH: begin
            flt_cyc_ff[i] <= 1'b0;
            // a live input blocks the clear, so set wins
            if (fact[i])
              flt_lat_ff[i] <= 1'b1;
            else if (fclr)
              flt_lat_ff[i] <= 1'b0;
          end
          mpft_pkg::FMODE_CYCLE: begin
            flt_lat_ff[i] <= 1'b0;
            if (fact[i])
              flt_cyc_ff[i] <= 1'b1;
            else if (groll[i])
              flt_cyc_ff[i] <= 1'b0;
          end
          default: begin
            flt_lat_ff[i] <= 1'b0;
            flt_cyc_ff[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // chop carrier, toggling every chop period plus one pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chcnt_ff <= '0;
      chop_clk_ff <= 1'b0;
    end else if (chcnt_ff >= chop_ff) begin
      chcnt_ff <= '0;
      chop_clk_ff <= ~chop_clk_ff;
    end else begin
      chcnt_ff <= chcnt_ff + 16'h0001;
    end
  end

  // output pins: duty compare, chop, swap, then fault override
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_pair <= '0;
    end else begin
      for (int i = 0; i < NGEN; i++) begin
        if (ctrl_ff[mpft_pkg::CTRL_SWAP]) begin
          pwm_pair[i].hi <= lraw[i];
          pwm_pair[i].lo <= hraw[i];
        end else begin
          pwm_pair[i].hi <= hraw[i];
          pwm_pair[i].lo <= lraw[i];
        end
        if (flt_lat_ff[i] || flt_cyc_ff[i] || lim_act[i] ||
            (fcl_ff[i][1:0] != mpft_pkg::FMODE_OFF && fact[i])) begin
          pwm_pair[i].hi <= fcl_ff[i][mpft_pkg::FCL_SAFE_H];
          pwm_pair[i].lo <= fcl_ff[i][mpft_pkg::FCL_SAFE_L];
        end
      end
    end
  end

  // trigger pulses and sync out, one cycle each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_trig <= '0;
      adc_sevt <= 1'b0;
      external_sync_output <= 1'b0;
    end else begin
      adc_trig <= trig_hit;
      adc_sevt <= sevt_hit;
      external_sync_output <= mroll & ctrl_ff[mpft_pkg::CTRL_EN];
    end
  end

  // sticky status; a read clears only the bits it returned, so an event
  // landing between setup and access survives; a new event wins the clear
  assign ev = {trig_hit, |(flt_lat_ff | flt_cyc_ff),
    mroll & ctrl_ff[mpft_pkg::CTRL_EN], sevt_hit};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stat_ff <= '0;
    else if (rd && paddr == mpft_pkg::OFF_STAT)
      stat_ff <= (stat_ff & ~rdata_ff[mpft_pkg::ST_W-1:0]) | ev;
    else
      stat_ff <= stat_ff | ev;
  end
  assign irq = |(stat_ff & mask_ff);
endmodule

// File: test/mpft_top_sva.sv
// checker for the motor pwm top: bus timing, reset state, pulse shapes
// assumes it is bound into mpft_top and sees only that module's ports
`timescale 1ns/100ps
module mpft_chk #(
  parameter int NGEN = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic safety_fault_owned,
  input wire mpft_pkg::mpft_pair_s [NGEN-1:0] pwm_pair,
  input wire logic [NGEN-1:0] adc_trig,
  input wire logic adc_sevt,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_now: assert property (psel && penable |-> pready)
    else $error("pready missing in access phase");
  chk_ready_only: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  chk_err_hole: assert property (psel && penable && paddr >= 8'h4c
    |-> pslverr) else $error("unmapped access not refused");
  chk_ctrl_ok: assert property (psel && penable
    && paddr == mpft_pkg::OFF_CTRL |-> !pslverr)
    else $error("control access refused");
  chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_owned_pin: assert property (safety_fault_owned)
    else $error("safety pin released");
  chk_start_safe: assert property ($rose(presetn) |->
    (pwm_pair == '0)[*2]) else $error("outputs active after reset");
  chk_sevt_pulse: assert property ($rose(adc_sevt) |=> !adc_sevt)
    else $error("special event pulse too long");
  cov_trig: cover property (adc_trig[0]);
  cov_sevt: cover property (adc_sevt);
  cov_irq: cover property ($rose(irq));
  cov_err: cover property (pslverr);
endmodule

bind mpft_top mpft_chk #(.NGEN(NGEN)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .safety_fault_owned(safety_fault_owned), .pwm_pair(pwm_pair),
  .adc_trig(adc_trig), .adc_sevt(adc_sevt), .irq(irq));

// File: test/mpft_stage.sv
// power stage and adc trigger model: counts generator 0 triggers and shoot-through
// assumes the pwm outputs and trigger pulses are registered on pclk
`timescale 1ns/100ps
module mpft_stage #(
  parameter int NGEN = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire mpft_pkg::mpft_pair_s [NGEN-1:0] pwm_pair,
  input wire logic [NGEN-1:0] adc_trig,
  output logic [7:0] trig_ff,
  output logic [7:0] shoot_ff
);
  // a real bridge would short here, so any overlap is only counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shoot_ff <= 8'h00;
    end else begin
      for (int i = 0; i < NGEN; i++) begin
        if (pwm_pair[i].hi && pwm_pair[i].lo) shoot_ff <= shoot_ff + 8'h01;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trig_ff <= 8'h00;
    else if (adc_trig[0]) trig_ff <= trig_ff + 8'h01;
  end
endmodule

// File: test/mpft_top_bench.sv
// self-checking bench for mpft_top driven as an apb master
// assumes zero-wait apb slave and the stage model beside it
`timescale 1ns/100ps
module mpft_top_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, slv, irq, adc_sevt;
  logic external_sync_output, safety_fault_owned;
  logic [5:0] fault_in = 6'h00;
  logic [5:0] limit_in = 6'h00;
  logic safety_fault_input = 1'b1;
  logic external_sync_input = 1'b0;
  mpft_pkg::mpft_pair_s [2:0] pwm_pair;
  logic [2:0] adc_trig;
  logic [7:0] trig_ff, shoot_ff;
  int err_total = 0;
  int n_checks = 0;
  always #20 pclk = ~pclk;
  mpft_top #(.NGEN(3)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_in(fault_in), .limit_in(limit_in),
    .safety_fault_input(safety_fault_input),
    .external_sync_input(external_sync_input),
    .external_sync_output(external_sync_output),
    .safety_fault_owned(safety_fault_owned), .pwm_pair(pwm_pair),
    .adc_trig(adc_trig), .adc_sevt(adc_sevt), .irq(irq));
  mpft_stage #(.NGEN(3)) i_stage (.pclk(pclk), .presetn(presetn),
    .pwm_pair(pwm_pair), .adc_trig(adc_trig), .trig_ff(trig_ff),
    .shoot_ff(shoot_ff));
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // entered just after an edge; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    slv = pslverr;
    check("pready", 1, n < 16);
    if (n >= 16) conclude();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, exp, rd & m);
  endtask
  function automatic logic [7:0] ga(input int i, input int w);
    return mpft_pkg::OFF_GEN0 + 8'(16 * i + 4 * w);
  endfunction
  function automatic bit seen(input int sel);
    case (sel)
      0: return adc_trig[0] === 1'b1;
      1: return adc_sevt === 1'b1;
      3: return adc_trig[1] === 1'b1;
      default: return external_sync_output === 1'b1;
    endcase
  endfunction
  task automatic await(input int sel, input string nm);
    int n;
    n = 0;
    while (n < 100 && !seen(sel)) begin
      @(posedge pclk);
      n++;
    end
    check(nm, 1, n < 100);
    if (n >= 100) conclude();
  endtask
  // edges until the next pulse, counted on from n0
  task automatic gap(input int sel, input int n0, input int exp,
    input string nm);
    int n;
    n = n0;
    do begin
      @(posedge pclk);
      n++;
    end while (!seen(sel) && n < 100);
    check(nm, exp, n);
    if (n >= 100) conclude();
  endtask
  task automatic t_reset;
    rdc("per0", ga(0, 0), 32'hffff, mpft_pkg::PER_RST);
    rdc("trig0", ga(0, 2), 32'hffff, mpft_pkg::TRIG_RST);
    rdc("fcl1", ga(1, 3), 32'h3f, mpft_pkg::FCL_RST);
    rdc("latched", mpft_pkg::OFF_FLTS, 32'h7, 32'h7);
    apb(1'b0, 8'h4c, 32'h0);
    check("slverr", 1, slv);
    check("hole", 0, rd);
    check("owned", 1, safety_fault_owned);
    $display("test reset done");
  endtask
  task automatic t_latch;
    wr(mpft_pkg::OFF_MPER, 32'h9);
    wr(ga(0, 1), 32'hffff);
    wr(mpft_pkg::OFF_CTRL, 32'h1);
    tick(5);
    check("safe", 0, 32'(pwm_pair));
    wr(ga(0, 3), 32'h1);
    rdc("fmode", ga(0, 3), 32'h3, 32'h1);
    wr(ga(0, 3), 32'h0);
    wr(mpft_pkg::OFF_CTRL, 32'h100);
    rdc("held", mpft_pkg::OFF_FLTS, 32'h7, 32'h7);
    safety_fault_input <= 1'b0;
    tick(4);
    wr(mpft_pkg::OFF_CTRL, 32'h100);
    rdc("cleared", mpft_pkg::OFF_FLTS, 32'h7, 32'h0);
    wr(mpft_pkg::OFF_CTRL, 32'h1);
    tick(5);
    check("run", 32'h16, 32'(pwm_pair));
    wr(mpft_pkg::OFF_CTRL, 32'h5);
    tick(5);
    check("swap", 32'h29, 32'(pwm_pair));
    wr(mpft_pkg::OFF_CTRL, 32'h1);
    $display("test latch done");
  endtask
  task automatic t_fault;
    wr(ga(1, 0), 32'h9);
    wr(ga(1, 3), 32'h11);
    fault_in <= 6'h08;
    tick(5);
    check("cycle", 32'h1a, 32'(pwm_pair));
    fault_in <= 6'h00;
    tick(30);
    check("cycle off", 32'h16, 32'(pwm_pair));
    wr(ga(2, 3), 32'h14);
    limit_in <= 6'h10;
    tick(5);
    check("limit", 32'h26, 32'(pwm_pair));
    limit_in <= 6'h00;
    tick(5);
    check("limit off", 32'h16, 32'(pwm_pair));
    wr(ga(0, 3), 32'h20);
    fault_in <= 6'h01;
    tick(5);
    fault_in <= 6'h00;
    tick(10);
    check("kept", 32'h15, 32'(pwm_pair));
    wr(mpft_pkg::OFF_CTRL, 32'h101);
    tick(5);
    check("unlatched", 32'h16, 32'(pwm_pair));
    $display("test fault done");
  endtask
  task automatic t_trig;
    wr(mpft_pkg::OFF_MASK, 32'h8);
    wr(ga(0, 0), 32'h9);
    wr(ga(0, 2), 32'h3);
    wr(ga(0, 3), 32'h8);
    await(0, "trig");
    tick(2);
    check("stage", 1, trig_ff != 8'h00);
    check("irq", 1, irq);
    wr(mpft_pkg::OFF_MASK, 32'h0);
    check("masked", 0, irq);
    wr(mpft_pkg::OFF_MASK, 32'h8);
    check("unmasked", 1, irq);
    // compare out of reach, so no new trigger can refill status bit 3
    wr(ga(0, 2), 32'hffff);
    rdc("status", mpft_pkg::OFF_STAT, 32'h8, 32'h8);
    rdc("cleared", mpft_pkg::OFF_STAT, 32'h8, 32'h0);
    check("irq low", 0, irq);
    $display("test trigger done");
  endtask
  task automatic t_sevt;
    wr(mpft_pkg::OFF_SEVT, 32'h2);
    wr(mpft_pkg::OFF_CTRL, 32'h81);
    external_sync_input <= 1'b1;
    tick(4);
    external_sync_input <= 1'b0;
    await(1, "sevt");
    await(2, "sync");
    tick(2);
    rdc("events", mpft_pkg::OFF_STAT, 32'h3, 32'h3);
    check("shoot", 0, shoot_ff);
    $display("test special event done");
  endtask
  task automatic t_modes;
    int hi_n, lo_n, t2_n;
    wr(mpft_pkg::OFF_CTRL, 32'h3);
    tick(2);
    await(2, "center roll");
    gap(2, 0, 18, "center period");
    wr(mpft_pkg::OFF_CTRL, 32'h21);
    tick(2);
    await(2, "prescale roll");
    gap(2, 0, 40, "prescale period");
    wr(mpft_pkg::OFF_CTRL, 32'h81);
    external_sync_input <= 1'b1;
    tick(5);
    gap(2, 5, 14, "restart");
    external_sync_input <= 1'b0;
    wr(mpft_pkg::OFF_CHOP, 32'h3);
    wr(mpft_pkg::OFF_CTRL, 32'h9);
    tick(4);
    hi_n = 0;
    lo_n = 0;
    t2_n = 0;
    repeat (8) begin
      @(posedge pclk);
      hi_n += pwm_pair[0].hi;
      lo_n += pwm_pair[0].lo;
      t2_n += adc_trig[2];
    end
    check("chop hi", 4, hi_n);
    check("chop lo", 0, lo_n);
    check("trig2 idle", 0, t2_n);
    wr(ga(2, 3), 32'h33);
    fault_in <= 6'h20;
    tick(5);
    check("mode off", 32'h1, 32'(pwm_pair[2]));
    fault_in <= 6'h00;
    wr(ga(1, 2), 32'h5);
    wr(ga(1, 3), 32'h8);
    tick(2);
    await(3, "trig1");
    gap(3, 0, 10, "trig1 period");
    $display("test modes done");
  endtask
  initial begin
    tick(10);
    presetn <= 1'b1;
    tick(1);
    t_reset();
    t_latch();
    t_fault();
    t_trig();
    t_sevt();
    t_modes();
    conclude();
  end
endmodule
